// file: common/tmo_chan_if.sv
// Link between the register bank and one timing field.
// Assumes both ends share the bank clock.
`timescale 1ns/10ps
`default_nettype none
interface tmo_chan_if;
  logic wr_en;
  logic [7:0] wdata;
  logic [6:0] auto_val;
  logic ovr;
  logic [6:0] value;

  modport ctrl (output wr_en, output wdata, output auto_val, input ovr, input value);
  modport field (input wr_en, input wdata, input auto_val, output ovr, output value);
endinterface
`default_nettype wire

// file: common/tmo_pkg.sv
// Constants and types of the D-PHY timing override register bank.
// Assumes byte-wide registers behind a plain strobe port on one clock.
//
// Summary of operation
// - HS-prepare bit 7 selects auto or programmed value
// - HS-zero bit 7 selects auto or programmed value
// - HS-trail bit 7 selects auto or programmed value
// - HS-exit low field used only while overridden
// - LP gap bit 7 overrides auto value
// - Port 1 clock-prepare uses same override scheme
// - Override clear: field writes ignored, reads auto
// - Override set: field is read/write
// - Auto values from 800 Mbps; follow rate
// - Reset fields 0x6, 0xC, 0x8, 0xB; overrides zero
// - Reset LP gap 0x6, clock-prepare 0x5
// - Clock-post at 0x43 same scheme, reset 0xA
package tmo_pkg;

  localparam int TMO_NCH = 7;
  localparam int TMO_NRATE = 5;

  // ----------------------------------------
  // Channel order
  // ----------------------------------------
  localparam int TMO_CH_CLK_POST = 0;
  localparam int TMO_CH_HS_PREP = 1;
  localparam int TMO_CH_HS_ZERO = 2;
  localparam int TMO_CH_HS_TRAIL = 3;
  localparam int TMO_CH_HS_EXIT = 4;
  localparam int TMO_CH_LP_GAP = 5;
  localparam int TMO_CH_P1_CLK_PREP = 6;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [TMO_NCH-1:0][7:0] TMO_OFFSET =
    {8'h60, 8'h48, 8'h47, 8'h46, 8'h45, 8'h44, 8'h43};
  localparam logic [7:0] TMO_STATUS_OFFSET = 8'h4f;
  localparam int TMO_OVERRIDE_BIT = 7;
  localparam int TMO_ST_PENDING_BIT = 0;
  localparam int TMO_ST_BURST_BIT = 1;
  localparam int TMO_ST_RATE_LSB = 2;

  typedef enum logic [2:0] {
    TMO_RATE_400,
    TMO_RATE_800,
    TMO_RATE_1200,
    TMO_RATE_1500,
    TMO_RATE_1600
  } tmo_rate_t;

  // ----------------------------------------
  // Automatic timing table, [rate][channel]
  // ----------------------------------------
  // Row 800 holds the field reset values
  localparam logic [TMO_NRATE-1:0][TMO_NCH-1:0][6:0] TMO_AUTO_TABLE = {
    {7'h0a, 7'h0a, 7'h10, 7'h0c, 7'h12, 7'h09, 7'h0f},
    {7'h09, 7'h09, 7'h0f, 7'h0b, 7'h11, 7'h08, 7'h0e},
    {7'h07, 7'h08, 7'h0d, 7'h0a, 7'h0f, 7'h07, 7'h0c},
    {7'h05, 7'h06, 7'h0b, 7'h08, 7'h0c, 7'h06, 7'h0a},
    {7'h03, 7'h04, 7'h08, 7'h05, 7'h08, 7'h04, 7'h08}
  };
  localparam tmo_rate_t TMO_RESET_RATE = TMO_RATE_800;
  localparam logic [TMO_NCH-1:0][6:0] TMO_RESET_VALUE =
    TMO_AUTO_TABLE[TMO_RESET_RATE];

endpackage

// file: dv/test_tmo_timing_override.sv
// Self-checking bench of the timing bank.
// Assumes the transmitter model supplies the burst level.
`timescale 1ns/10ps
`default_nettype none
module test_tmo_timing_override
  import tmo_pkg::*;
;
  logic clk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, start = 0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [2:0] lane_rate_sel = 3'h1;
  logic hs_burst_active, update_pending;
  logic [TMO_NCH-1:0][6:0] tx_timing;
  int errors = 0, compares = 0, cycles = 0;
  // Write flag, address, data or expected read
  logic [16:0] rows [13] = '{17'h0430a, 17'h04406, 17'h0450c, 17'h04608, 17'h0470b, 17'h04806,
    17'h06005, 17'h05000, 17'h04f04, 17'h14615, 17'h04608, 17'h1607f, 17'h06005};
  tmo_timing_override i_tmo_timing_override (.clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .lane_rate_sel, .hs_burst_active, .tx_timing, .update_pending);
  tmo_tx_model i_tmo_tx_model (.clk, .reset_n, .start, .len(8'h14), .hs_burst_active);
  initial forever #25 clk = ~clk;
  task automatic end_of_test();
    if (errors == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e)
    begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // Leaves one idle edge after each strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    // Data lands after this edge; look at the next one, before it moves
    @(posedge clk);
    chk(reg_rdata, e);
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 1000)
    begin
      errors++;
      end_of_test();
    end
  end
  initial
  begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    foreach (rows[i])
      if (rows[i][16])
        wr(rows[i][15:8], rows[i][7:0]);
      else
        rd(rows[i][15:8], rows[i][7:0]);
    for (int c = 0; c < TMO_NCH; c++)
    begin
      wr(TMO_OFFSET[c], 8'h80);
      wr(TMO_OFFSET[c], 8'h91 + c[7:0]);
      rd(TMO_OFFSET[c], 8'h91 + c[7:0]);
      chk({1'b0, tx_timing[c]}, 8'h11 + c[7:0]);
      wr(TMO_OFFSET[c], 8'h00);
    end
    // Code 7 is illegal, so the 1600 values stay
    for (int r = 0; r < 6; r++)
    begin
      lane_rate_sel <= (r == 5) ? 3'h7 : r[2:0];
      rd(8'h45, {1'b0, TMO_AUTO_TABLE[(r == 5) ? 4 : r][2]});
      chk({1'b0, tx_timing[2]}, {1'b0, TMO_AUTO_TABLE[(r == 5) ? 4 : r][2]});
    end
    lane_rate_sel <= 3'h1;
    // Let the 800 values reach the lane before the burst freezes it
    repeat (2) @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    wr(8'h47, 8'h80);
    wr(8'h47, 8'h9a);
    rd(TMO_STATUS_OFFSET, 8'h07);
    chk({1'b0, tx_timing[4]}, 8'h0b);
    chk({7'h00, update_pending}, 8'h01);
    for (int i = 0; i < 40 && hs_burst_active; i++)
      @(posedge clk);
    repeat (2) @(posedge clk);
    chk({1'b0, tx_timing[4]}, 8'h1a);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    rd(8'h47, 8'h0b);
    end_of_test();
  end
endmodule
`default_nettype wire

// file: dv/tmo_timing_props.sv
// Port checker of the timing bank, bound to its top module.
// Assumes one clock domain.
`timescale 1ns/10ps
`default_nettype none
module tmo_timing_props
  import tmo_pkg::*;
#(
  parameter int NCH = TMO_NCH
)
(
  input wire logic clk, // Clock
  input wire logic reset_n, // Reset, active low
  input wire logic [7:0] reg_addr, // Address
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  input wire logic [7:0] reg_rdata, // Read data
  input wire logic [2:0] lane_rate_sel, // Rate code
  input wire logic hs_burst_active, // Burst level
  input wire logic [NCH-1:0][6:0] tx_timing, // Applied values
  input wire logic update_pending // Deferred change
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_rd_gap;
    reg_rd ##1 !reg_rd;
  endsequence
  property p_rd_gap;
    s_rd_gap |=> reg_rdata == 8'h00;
  endproperty
  a_rd_gap: assert property (p_rd_gap) else $error("read data stood too long");
  property p_rd_src;
    reg_rdata != 8'h00 |-> $past(reg_rd);
  endproperty
  a_rd_src: assert property (p_rd_src) else $error("read data without strobe");
  property p_unmapped;
    reg_rd && reg_addr == 8'h50 |=> reg_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_freeze;
    hs_burst_active |=> $stable(tx_timing);
  endproperty
  a_freeze: assert property (p_freeze) else $error("timing moved in burst");
  property p_apply;
    update_pending && !hs_burst_active |=> $changed(tx_timing);
  endproperty
  a_apply: assert property (p_apply) else $error("pending value not applied");
  property p_idle;
    !update_pending |=> $stable(tx_timing);
  endproperty
  a_idle: assert property (p_idle) else $error("timing moved without cause");
  property p_status;
    reg_rd && reg_addr == TMO_STATUS_OFFSET |=>
      reg_rdata[1:0] == {$past(hs_burst_active), $past(update_pending)};
  endproperty
  a_status: assert property (p_status) else $error("status bits wrong");
  property p_rd_eff(int c);
    reg_rd && reg_addr == TMO_OFFSET[c] && !update_pending |=> reg_rdata[6:0] == $past(tx_timing[c]);
  endproperty
  for (genvar g = 0; g < NCH; g++)
  begin : g_ch
    a_rd_eff: assert property (p_rd_eff(g)) else $error("field read not effective value");
  end
endmodule
bind tmo_timing_override tmo_timing_props #(.NCH(NCH)) i_tmo_timing_props (.clk, .reset_n, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .lane_rate_sel, .hs_burst_active, .tx_timing, .update_pending);
`default_nettype wire

// file: dv/tmo_tx_model.sv
// Lane transmitter stand-in: holds HS burst for len cycles per start.
// Assumes start is a one-cycle pulse from the bench.
`timescale 1ns/10ps
`default_nettype none
module tmo_tx_model
(
  input wire logic clk, // Bank clock
  input wire logic reset_n, // Async reset, active low
  input wire logic start, // Begin a burst
  input wire logic [7:0] len, // Burst length, cycles
  output var logic hs_burst_active // Inside HS burst
);
  logic [7:0] cnt_q;
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
      cnt_q <= 8'h00;
    else if (start)
      cnt_q <= len;
    else if (cnt_q != 8'h00)
      cnt_q <= cnt_q - 8'h01;
  assign hs_burst_active = cnt_q != 8'h00;
endmodule
`default_nettype wire

// file: rtl/tmo_auto_select.sv
// Automatic timing selection from the lane rate.
// Assumes the rate code is synchronous to clk.
`timescale 1ns/10ps
`default_nettype none
module tmo_auto_select
  import tmo_pkg::*;
(
  input wire logic clk, // Bank clock
  input wire logic reset_n, // Async reset, active low
  input wire logic [2:0] rate_sel, // Lane rate code
  output var logic rate_ok, // Rate code is legal
  output var logic [TMO_NCH-1:0][6:0] auto_val // Auto values
);

  assign rate_ok = (rate_sel < 3'(TMO_NRATE));

  // Illegal codes keep the last legal timing
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      auto_val <= TMO_RESET_VALUE;
    end
    else if (rate_ok)
    begin
      auto_val <= TMO_AUTO_TABLE[rate_sel];
    end
  end

endmodule
`default_nettype wire

// file: rtl/tmo_timing_field.sv
// One timing register: override bit and seven-bit value.
// Assumes writes arrive as single-cycle strobes.
`timescale 1ns/10ps
`default_nettype none
module tmo_timing_field
  import tmo_pkg::*;
#(
  parameter logic [6:0] RESET_VALUE = 7'h00
)
(
  input wire logic clk, // Bank clock
  input wire logic reset_n, // Async reset, active low
  tmo_chan_if.field ch // Register side
);

  logic ovr_q;
  logic [6:0] manual_q;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ovr_q <= 1'b0;
    end
    else if (ch.wr_en)
    begin
      ovr_q <= ch.wdata[TMO_OVERRIDE_BIT];
    end
  end

  // Entering override seeds the auto value so the lane sees no jump
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      manual_q <= RESET_VALUE;
    end
    else if (ch.wr_en && ovr_q)
    begin
      manual_q <= ch.wdata[6:0];
    end
    else if (ch.wr_en && ch.wdata[TMO_OVERRIDE_BIT])
    begin
      manual_q <= ch.auto_val;
    end
  end

  assign ch.ovr = ovr_q;
  assign ch.value = ovr_q ? manual_q : ch.auto_val;

endmodule
`default_nettype wire

// file: rtl/tmo_timing_override.sv
// D-PHY timing override register bank with applied-value staging.
// Assumes a plain strobe register port and an HS burst indicator
// from the lane transmitter, both synchronous to clk.
`timescale 1ns/10ps
`default_nettype none
module tmo_timing_override
  import tmo_pkg::*;
#(
  parameter int NCH = TMO_NCH
)
(
  input wire logic clk, // 20 MHz bank clock
  input wire logic reset_n, // Async reset, active low
  input wire logic [7:0] reg_addr, // Register address
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output var logic [7:0] reg_rdata, // Read data, cycle after strobe
  input wire logic [2:0] lane_rate_sel, // Lane rate code
  input wire logic hs_burst_active, // Transmitter inside HS burst
  output var logic [NCH-1:0][6:0] tx_timing, // Applied timing values
  output var logic update_pending // New value waits for burst end
);

  // ----------------------------------------
  // Automatic values
  // ----------------------------------------
  logic rate_ok;
  logic [NCH-1:0][6:0] auto_val;
  logic [2:0] rate_q;

  tmo_auto_select u_auto (
    .clk(clk),
    .reset_n(reset_n),
    .rate_sel(lane_rate_sel),
    .rate_ok(rate_ok),
    .auto_val(auto_val)
  );

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rate_q <= 3'(TMO_RESET_RATE);
    end
    else if (rate_ok)
    begin
      rate_q <= lane_rate_sel;
    end
  end

  // ----------------------------------------
  // Timing fields
  // ----------------------------------------
  logic [NCH-1:0] ovr;
  logic [NCH-1:0][6:0] value;

  generate
    for (genvar i = 0; i < NCH; i++)
    begin : g_ch
      tmo_chan_if ch_if ();

      assign ch_if.wr_en = reg_wr && (reg_addr == TMO_OFFSET[i]);
      assign ch_if.wdata = reg_wdata;
      assign ch_if.auto_val = auto_val[i];
      assign ovr[i] = ch_if.ovr;
      assign value[i] = ch_if.value;

      tmo_timing_field #(
        .RESET_VALUE(TMO_RESET_VALUE[i])
      ) u_field (
        .clk(clk),
        .reset_n(reset_n),
        .ch(ch_if.field)
      );
    end
  endgenerate

  // ----------------------------------------
  // Applied values
  // ----------------------------------------
  // Changing timing mid-burst would corrupt the HS sequence,
  // so new values wait until the lane is idle
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tx_timing <= TMO_RESET_VALUE;
    end
    else if (!hs_burst_active)
    begin
      tx_timing <= value;
    end
  end

  assign update_pending = (tx_timing != value);

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  logic [7:0] rdata_d;

  always_comb
  begin
    rdata_d = 8'h00;
    for (int i = 0; i < NCH; i++)
    begin
      if (reg_addr == TMO_OFFSET[i])
      begin
        rdata_d = {ovr[i], value[i]};
      end
    end
    if (reg_addr == TMO_STATUS_OFFSET)
    begin
      rdata_d[TMO_ST_PENDING_BIT] = update_pending;
      rdata_d[TMO_ST_BURST_BIT] = hs_burst_active;
      rdata_d[TMO_ST_RATE_LSB +: 3] = rate_q;
    end
  end

  // Data stands only in the cycle after the strobe
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      reg_rdata <= 8'h00;
    end
    else
    begin
      reg_rdata <= reg_rd ? rdata_d : 8'h00;
    end
  end

endmodule
`default_nettype wire
